// ---- core/mwt_pkg.sv ----
// package for the minute watchdog timer: register map, reset values, timing constants
package mwt_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] ADDR_FACTOR = 4'h0;   // timer factor, write only
  localparam logic [3:0] ADDR_STATUS = 4'h1;   // sticky event status, write one to clear
  localparam logic [3:0] ADDR_MASK = 4'h2;     // interrupt mask, one enables
  localparam logic [3:0] ADDR_STATE = 4'h3;    // live state, read only

  // status and mask bit positions
  localparam int BIT_EXPIRE = 0;               // countdown ran out
  localparam int BIT_RETRIG = 1;               // retrigger write taken
  localparam int BIT_DISABLE = 2;              // disable write taken
  localparam int EVT_W = 3;                    // number of event bits

  // values after reset
  localparam logic [7:0] FACTOR_RST = 8'h00;   // disabled
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0; // all events masked

  // time-out formula: first_period + step * (factor - 1), seconds
  localparam int FIRST_S = 30;                 // time-out for factor 1
  localparam int STEP_S = 60;                  // added per factor step
  localparam int SEC_W = 14;                   // holds 30 + 60*254 = 15270

  // clock and timebase
  localparam int CLK_HZ = 100_000_000;         // system clock rate
  localparam int TICK_S = 1;                   // counting tick period, seconds
  localparam int TICK_CYC = CLK_HZ * TICK_S;   // cycles per tick
  localparam int RST_PULSE_NS = 1000;          // reset pulse width, ns
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * 100 + 999) / 1000; // rounded up at 10 ns
  localparam int BLINK_TICKS = 1;              // led toggles every tick

  // one register port request
  typedef struct packed {
    logic [3:0] addr;                          // register offset
    logic [7:0] wdata;                         // write data
    logic wr;                                  // write strobe
    logic rd;                                  // read strobe
  } mwt_req_type;

  // watchdog countdown state
  typedef enum logic [1:0] {
    MWT_IDLE,                                  // disabled
    MWT_COUNT,                                 // counting down
    MWT_FIRE                                   // reset pulse out
  } mwt_state_type;

endpackage : mwt_pkg

// ---- core/mwt_prescaler.sv ----
// one-second tick prescaler for the minute watchdog timer
`timescale 1ns/100ps
module mwt_prescaler #(
  parameter int DIV = 100_000_000                // clock cycles per tick
) (
  input wire logic i_clk,                        // system clock
  input wire logic i_rst_n,                      // synchronous reset, active low
  input wire logic i_ce,                         // clock enable
  input wire logic i_restart,                    // realign the tick phase
  output logic o_tick                            // one-cycle tick pulse
);

  localparam int CW = $clog2(DIV + 1);           // counter width
  localparam logic [CW-1:0] LAST = CW'(DIV - 1); // terminal count

  logic [CW-1:0] cnt;                            // cycle counter

  ////////////////////////////////////////////////////////////////////////////
  // divider, restarted on every retrigger so a full period follows
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (i_restart) begin
        cnt <= '0;
        o_tick <= 1'b0;
      end else if (cnt == LAST) begin
        cnt <= '0;
        o_tick <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
        o_tick <= 1'b0;
      end
    end
  end

endmodule // mwt_prescaler

// ---- core/mwt_watchdog.sv ----
// minute watchdog timer: factor register, second countdown, reset pulse, led and interrupt
`timescale 1ns/100ps
module mwt_watchdog #(
  parameter int TICK_DIV = mwt_pkg::TICK_CYC,        // cycles per second tick
  parameter int PULSE_CYC = mwt_pkg::RST_PULSE_CYC   // reset pulse width, cycles
) (
  input wire logic i_clk,                            // system clock, 100 MHz
  input wire logic i_rst_n,                          // synchronous reset, active low
  input wire logic i_ce,                             // clock enable, freezes all state
  input wire logic [3:0] i_addr,                     // register offset
  input wire logic [7:0] i_wdata,                    // write data
  input wire logic i_wr,                             // write strobe
  input wire logic i_rd,                             // read strobe
  output logic [7:0] o_rdata,                        // read data, cycle after strobe
  output logic o_sys_rst,                            // reset pulse to system, high active
  output logic o_led,                                // blinking indicator
  output logic o_irq                                 // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  localparam int PW = $clog2(PULSE_CYC + 1);         // pulse counter width

  mwt_pkg::mwt_req_type req;                         // bundled request
  mwt_pkg::mwt_state_type state;                     // countdown state
  logic [7:0] factor;                                // current timer factor
  logic [mwt_pkg::SEC_W-1:0] secs;                   // seconds remaining
  logic [PW-1:0] pulse_cnt;                          // reset pulse cycles left
  logic [mwt_pkg::EVT_W-1:0] status;                 // sticky events
  logic [mwt_pkg::EVT_W-1:0] mask;                   // interrupt enables
  logic [mwt_pkg::EVT_W-1:0] events;                 // this cycle's events
  logic [mwt_pkg::EVT_W-1:0] clr;                    // write-one-to-clear bits
  logic wr_factor;                                   // factor write this cycle
  logic tick;                                        // one-second tick
  logic expire;                                      // countdown reaches end

  // time-out in seconds for a nonzero factor
  function automatic logic [mwt_pkg::SEC_W-1:0] timeout_s(input logic [7:0] f);
    logic [mwt_pkg::SEC_W-1:0] n;
    n = mwt_pkg::SEC_W'(f) - 1'b1;
    return mwt_pkg::SEC_W'(mwt_pkg::FIRST_S) + mwt_pkg::SEC_W'(n * mwt_pkg::SEC_W'(mwt_pkg::STEP_S));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wr_factor = req.wr && (req.addr == mwt_pkg::ADDR_FACTOR);
  assign expire = (state == mwt_pkg::MWT_COUNT) && tick && (secs == mwt_pkg::SEC_W'(1));
  assign clr = (req.wr && req.addr == mwt_pkg::ADDR_STATUS) ? req.wdata[mwt_pkg::EVT_W-1:0] : '0;

  // event collection for the status register
  always_comb begin
    events = '0;
    events[mwt_pkg::BIT_EXPIRE] = expire && !wr_factor;
    // factor writes during the reset pulse are refused, so they log nothing
    events[mwt_pkg::BIT_RETRIG] = wr_factor && (req.wdata != 8'h00) && (state != mwt_pkg::MWT_FIRE);
    events[mwt_pkg::BIT_DISABLE] = wr_factor && (req.wdata == 8'h00) && (state != mwt_pkg::MWT_FIRE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // second tick, realigned by every factor write
  mwt_prescaler #(
    .DIV(TICK_DIV)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_restart(wr_factor),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // factor register and countdown state machine
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= mwt_pkg::MWT_IDLE;
      factor <= mwt_pkg::FACTOR_RST;
      secs <= '0;
      pulse_cnt <= '0;
    end else if (i_ce) begin
      case (state)
        mwt_pkg::MWT_IDLE: begin
          if (wr_factor && req.wdata != 8'h00) begin
            factor <= req.wdata;
            secs <= timeout_s(req.wdata);
            state <= mwt_pkg::MWT_COUNT;
          end
        end
        mwt_pkg::MWT_COUNT: begin
          if (wr_factor) begin
            factor <= req.wdata;
            if (req.wdata == 8'h00) begin
              state <= mwt_pkg::MWT_IDLE;
              secs <= '0;
            end else begin
              secs <= timeout_s(req.wdata);
            end
          end else if (expire) begin
            state <= mwt_pkg::MWT_FIRE;
            secs <= '0;
            pulse_cnt <= PW'(PULSE_CYC);
          end else if (tick) begin
            secs <= secs - 1'b1;
          end
        end
        mwt_pkg::MWT_FIRE: begin
          // pulse runs its full width; then we drop to idle and reload the reset factor
          if (pulse_cnt == PW'(1)) begin
            state <= mwt_pkg::MWT_IDLE;
            factor <= mwt_pkg::FACTOR_RST;
            pulse_cnt <= '0;
          end else begin
            pulse_cnt <= pulse_cnt - 1'b1;
          end
        end
        default: begin
          state <= mwt_pkg::MWT_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse output, registered
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sys_rst <= 1'b0;
    end else if (i_ce) begin
      if (expire && !wr_factor) begin
        o_sys_rst <= 1'b1;
      end else if (state == mwt_pkg::MWT_FIRE && pulse_cnt == PW'(1)) begin
        o_sys_rst <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator led: toggles each tick while counting, dark otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_led <= 1'b0;
    end else if (i_ce) begin
      if (state != mwt_pkg::MWT_COUNT || (wr_factor && req.wdata == 8'h00)) begin
        o_led <= 1'b0;
      end else if (tick) begin
        o_led <= ~o_led;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status, set wins over clear; mask register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      status <= '0;
      mask <= mwt_pkg::MASK_RST;
    end else if (i_ce) begin
      status <= (status & ~clr) | events;
      if (req.wr && req.addr == mwt_pkg::ADDR_MASK) begin
        mask <= req.wdata[mwt_pkg::EVT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt level, registered from the next status value
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(((status & ~clr) | events) & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (req.rd) begin
        case (req.addr)
          mwt_pkg::ADDR_STATUS: o_rdata <= 8'(status);
          mwt_pkg::ADDR_MASK: o_rdata <= 8'(mask);
          mwt_pkg::ADDR_STATE: o_rdata <= {5'h00, o_led, state == mwt_pkg::MWT_FIRE, state == mwt_pkg::MWT_COUNT};
          default: o_rdata <= 8'h00;               // factor is write only; unmapped reads zero
        endcase
      end
    end
  end

endmodule // mwt_watchdog

// ---- sim/mwt_props.sv ----
// assertion checker for the minute watchdog timer ports
`timescale 1ns/100ps
module mwt_props #(
  parameter int TICK_DIV = 4,              // cycles per second tick
  parameter int PULSE_CYC = 4              // reset pulse width, cycles
) (
  input wire logic i_clk,                  // system clock
  input wire logic i_rst_n,                // synchronous reset, active low
  input wire logic i_ce,                   // clock enable
  input wire logic [3:0] i_addr,           // register offset
  input wire logic [7:0] i_wdata,          // write data
  input wire logic i_wr,                   // write strobe
  input wire logic i_rd,                   // read strobe
  input wire logic [7:0] o_rdata,          // read data
  input wire logic o_sys_rst,              // reset pulse
  input wire logic o_led,                  // indicator
  input wire logic o_irq                   // interrupt
);
  localparam int LED_WAIT = TICK_DIV + 4;  // first led toggle bound
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic fwr;                               // factor write taken
  logic [7:0] last_f;                      // last factor written
  int since;                               // cycles since factor write
  int hi_cnt;                              // pulse length so far
  int exp_cyc;                             // expected time-out, cycles
  assign fwr = i_wr && i_ce && i_addr == mwt_pkg::ADDR_FACTOR && !o_sys_rst;
  assign exp_cyc = (30 + 60 * (int'(last_f) - 1)) * TICK_DIV;
  // cycle counters beside the ports
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      since <= 0;
      last_f <= 8'h00;
      hi_cnt <= 0;
    end else begin
      since <= fwr ? 0 : since + 1;
      last_f <= fwr ? i_wdata : last_f;
      hi_cnt <= o_sys_rst ? hi_cnt + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_rst_quiet; $rose(i_rst_n) |-> !o_sys_rst && !o_led && !o_irq; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_retrig_hold; fwr && i_wdata != 8'h00 |=> !o_sys_rst [*8]; endproperty
  a_retrig_hold: assert property (p_retrig_hold) else $error("pulse right after retrigger");
  property p_enable_led; fwr && i_wdata != 8'h00 |-> ##[1:LED_WAIT] $changed(o_led); endproperty
  a_enable_led: assert property (p_enable_led) else $error("led not blinking");
  property p_timeout; $rose(o_sys_rst) |-> since >= exp_cyc && since <= exp_cyc + 3; endproperty
  a_timeout: assert property (p_timeout) else $error("pulse at wrong time");
  property p_pulse_width; $fell(o_sys_rst) |-> hi_cnt == PULSE_CYC; endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_pulse_cap; hi_cnt <= PULSE_CYC; endproperty
  a_pulse_cap: assert property (p_pulse_cap) else $error("pulse too long");
  property p_disable_quiet; fwr && i_wdata == 8'h00 |=> !o_sys_rst [*8]; endproperty
  a_disable_quiet: assert property (p_disable_quiet) else $error("pulse after disable");
  property p_disable_led; fwr && i_wdata == 8'h00 |-> ##2 !o_led; endproperty
  a_disable_led: assert property (p_disable_led) else $error("led on after disable");
  property p_after_pulse; $fell(o_sys_rst) |-> !o_led; endproperty
  a_after_pulse: assert property (p_after_pulse) else $error("led on after expiry");
  c_pulse: cover property ($rose(o_sys_rst));
  c_disable: cover property (fwr && i_wdata == 8'h00);
  c_irq: cover property ($rose(o_irq));
endmodule // mwt_props
bind mwt_watchdog mwt_props #(.TICK_DIV(TICK_DIV), .PULSE_CYC(PULSE_CYC)) mwt_props_inst (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_sys_rst(o_sys_rst), .o_led(o_led), .o_irq(o_irq));

// ---- sim/mwt_watchdog_test.sv ----
// self-checking bench for the minute watchdog timer
`timescale 1ns/100ps
module mwt_watchdog_test;
  localparam int TDIV = 4;                 // short tick for simulation
  localparam int PW = 4;                   // short reset pulse
  logic i_clk = 1'b0;                      // clock
  logic i_rst_n = 1'b0;                    // reset, active low
  logic i_ce = 1'b1;                       // clock enable
  logic [3:0] i_addr = 4'h0;               // offset
  logic [7:0] i_wdata = 8'h00;             // write data
  logic i_wr = 1'b0;                       // write strobe
  logic i_rd = 1'b0;                       // read strobe
  logic [7:0] o_rdata;                     // read data
  logic o_sys_rst;                         // reset pulse
  logic o_led;                             // indicator
  logic o_irq;                             // interrupt
  int error_cnt = 0;                       // mismatches
  int tests_run = 0;                       // comparisons
  int seed = 68048;                        // random seed
  int hi_cyc = 0;                          // pulse cycles seen
  int fq[$] = '{1, 2};                     // factors to try
  int n;                                   // scratch count
  logic lv;                                // last led level
  logic [7:0] d;                           // read value
  mwt_watchdog #(.TICK_DIV(TDIV), .PULSE_CYC(PW)) mwt_watchdog_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_sys_rst(o_sys_rst), .o_led(o_led), .o_irq(o_irq));
  always #5 i_clk = ~i_clk;
  // total reset pulse cycles
  always @(posedge i_clk) if (o_sys_rst === 1'b1) hi_cyc++;
  ////////////////////////////////////////////////////////////////////////////
  // model: time-out in cycles for a factor
  function automatic int tout(input int f);
    return (30 + 60 * (f - 1)) * TDIV;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask
  // measures pulse start from the taking edge, then its width
  task automatic wait_pulse(input int exp_c);
    int k;
    int m;
    k = 0;
    m = 0;
    while (o_sys_rst !== 1'b1 && k < exp_c + 50) begin
      @(posedge i_clk);
      #1 k++;
    end
    check(k >= exp_c && k <= exp_c + 3, 1'b1);
    while (o_sys_rst === 1'b1 && m < 20) begin
      @(posedge i_clk);
      #1 m++;
    end
    check(m, PW);
  endtask
  task automatic print_verdict;
    $display("error_cnt=%0d tests_run=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(mwt_pkg::ADDR_STATE, d);
    check(d, 8'h00);
    repeat (150) @(posedge i_clk);
    check({o_sys_rst, o_led, o_irq}, 3'b000);
    check(hi_cyc, 0);
    rd(4'hf, d);
    check(d, 8'h00);
    wr(mwt_pkg::ADDR_MASK, 8'h07);
    fq.push_back(1 + $unsigned($random(seed)) % 3);
    foreach (fq[i]) begin
      wr(mwt_pkg::ADDR_STATUS, 8'h07);
      wr(mwt_pkg::ADDR_FACTOR, 8'hff);
      repeat (10) @(posedge i_clk);
      wr(mwt_pkg::ADDR_FACTOR, fq[i][7:0]);
      for (int k = 0; k < 2; k++) begin
        repeat (tout(fq[i]) / 2 + $unsigned($random(seed)) % 20) @(posedge i_clk);
        wr(mwt_pkg::ADDR_FACTOR, fq[i][7:0]);
      end
      check(hi_cyc, PW * i);
      wait_pulse(tout(fq[i]));
      rd(mwt_pkg::ADDR_STATUS, d);
      check({d, o_irq, o_led}, {8'h03, 2'b10});
      wr(mwt_pkg::ADDR_MASK, 8'h00);
      repeat (2) @(posedge i_clk);
      #1 check(o_irq, 1'b0);
      wr(mwt_pkg::ADDR_MASK, 8'h07);
    end
    // enable, watch blinking, then switch off
    wr(mwt_pkg::ADDR_STATUS, 8'h07);
    wr(mwt_pkg::ADDR_FACTOR, 8'h01);
    n = 0;
    lv = o_led;
    for (int k = 0; k < 3 * TDIV; k++) begin
      @(negedge i_clk);
      if (o_led !== lv) n++;
      lv = o_led;
    end
    check(n >= 2, 1'b1);
    // clock enable low freezes countdown and led well past a time-out
    @(posedge i_clk);
    i_ce <= 1'b0;
    @(posedge i_clk);
    #1 lv = o_led;
    repeat (200) @(posedge i_clk);
    #1 check({hi_cyc, o_led}, {PW * fq.size(), lv});
    @(posedge i_clk);
    i_ce <= 1'b1;
    wr(mwt_pkg::ADDR_FACTOR, 8'h00);
    repeat (300) @(posedge i_clk);
    check({hi_cyc, o_led}, {PW * fq.size(), 1'b0});
    rd(mwt_pkg::ADDR_STATUS, d);
    check(d, 8'h06);
    print_verdict();
  end
  // hang guard
  initial begin
    #(20000 * 10);
    error_cnt++;
    print_verdict();
  end
endmodule // mwt_watchdog_test
